// file: rtl/brf_core.sv
// banked core register file with byte-lane steering
`timescale 1ns/100ps
`include "brf_map.svh"
// Function
// - 37 physical registers: 31 general, 6 status
// - wide state: sixteen registers plus status visible
// - branch with link copies r15 to link
// - wide state: counter in bits 31:2
// - compact state: counter in bits 31:1
// - privileged modes except system see their saved status
// - banked copies kept while other modes run
// - fast mode banks indices 8 to 14
// - other exception modes bank 13 and 14
// - system mode uses user registers
// - compact state sees 0-7, stack, link, counter
// - compact registers alias wide registers
// - seven modes, all but user privileged
// - system mode only via status write
// - abort and undefined entered by exceptions
// - little endian: address 0 on lines 7:0
// - big endian: address 0 on lines 31:24
// - memory byte addressed, words four-aligned
// - words four-aligned, halves two-aligned
// - exception entry loads target link register
// - mode field encoding selects the bank
// - state bit selects compact or wide view
module brf_core (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             big_endian_cfg,
    input  wire logic [3:0]       rd_idx,
    input  wire brf_pkg::brf_wr_s wr_req,
    input  wire logic             branch_with_link,
    input  wire brf_pkg::brf_exc_s exc_req,
    input  wire logic             status_wr,
    input  wire logic [31:0]      status_wdata,
    input  wire logic             saved_status_wr,
    input  wire logic [31:0]      saved_status_wdata,
    input  wire brf_pkg::brf_mem_s mem_req,
    input  wire logic [31:0]      mem_rdata,
    output logic [31:0]           rd_data,
    output logic [31:0]           program_counter,
    output logic [31:0]           stack_pointer,
    output logic [31:0]           return_link_register,
    output logic [31:0]           current_status_word,
    output logic [31:0]           saved_status_word,
    output logic                  privileged,
    output logic                  compact_state,
    output logic [31:0]           lane_wdata,
    output logic [3:0]            lane_be,
    output logic [31:0]           lane_rdata,
    output logic                  misaligned
);
    import brf_pkg::*;

    // ************************************************************
    // state and helpers
    // ************************************************************
    brf_state_s st;           // registered state
    brf_state_s next_st;      // next state
    logic       rst_int_b;    // released reset copy
    brf_bank_e  bank;         // current bank
    logic       priv;         // privileged flag
    logic       compact;      // compact view flag
    logic [4:0] cur_mode;     // current mode field

    // physical index map: 0-14 user r0-r14, 15 pc, 16-22 fast r8-r14,
    // 23-24 irq, 25-26 svc, 27-28 abt, 29-30 und (link, sp)
    // status: 0 current, 1 fast, 2 irq, 3 svc, 4 abt, 5 und

    // ************************************************************
    // mode decode
    // ************************************************************
    // map mode field to a bank; system shares user
    function automatic brf_bank_e mode_bank(input logic [4:0] m);
        brf_bank_e b;
        b = BRF_BANK_USER;
        case (m)
            `BRF_MODE_FAST: b = BRF_BANK_FAST;
            `BRF_MODE_IRQ:  b = BRF_BANK_IRQ;
            `BRF_MODE_SVC:  b = BRF_BANK_SVC;
            `BRF_MODE_ABT:  b = BRF_BANK_ABT;
            `BRF_MODE_UND:  b = BRF_BANK_UND;
            default:        b = BRF_BANK_USER; // user, system, illegal
        endcase
        return b;
    endfunction

    // saved status slot for a bank, 0 means none
    function automatic logic [2:0] stat_slot(input brf_bank_e b);
        logic [2:0] s;
        s = 3'h0;
        case (b)
            BRF_BANK_FAST: s = 3'h1;
            BRF_BANK_IRQ:  s = 3'h2;
            BRF_BANK_SVC:  s = 3'h3;
            BRF_BANK_ABT:  s = 3'h4;
            BRF_BANK_UND:  s = 3'h5;
            default:       s = 3'h0;
        endcase
        return s;
    endfunction

    // visible index to physical slot for a bank
    function automatic logic [4:0] phys(input brf_bank_e b, input logic [3:0] i);
        logic [4:0] p;
        p = {1'b0, i};
        case (b)
            BRF_BANK_FAST: if (i >= `BRF_IDX_FAST_LO && i != `BRF_IDX_PC) begin
                p = {1'b0, i} + 5'h08;                 // 16..22, sum kept at five bits
            end
            BRF_BANK_IRQ:  if (i == `BRF_IDX_SP || i == `BRF_IDX_LINK) begin
                p = 5'(5'h17 + {4'h0, i[0]});          // 23..24
            end
            BRF_BANK_SVC:  if (i == `BRF_IDX_SP || i == `BRF_IDX_LINK) begin
                p = 5'(5'h19 + {4'h0, i[0]});          // 25..26
            end
            BRF_BANK_ABT:  if (i == `BRF_IDX_SP || i == `BRF_IDX_LINK) begin
                p = 5'(5'h1B + {4'h0, i[0]});          // 27..28
            end
            BRF_BANK_UND:  if (i == `BRF_IDX_SP || i == `BRF_IDX_LINK) begin
                p = 5'(5'h1D + {4'h0, i[0]});          // 29..30
            end
            default:       p = {1'b0, i};              // user and system
        endcase
        return p;
    endfunction

    assign rst_int_b = st.rst_sync[1];
    assign cur_mode  = st.stat[0][`BRF_STAT_MODE_HI:`BRF_STAT_MODE_LO];
    assign bank      = mode_bank(cur_mode);
    assign priv      = (cur_mode != `BRF_MODE_USER);
    assign compact   = st.stat[0][`BRF_STAT_T_BIT];

    // ************************************************************
    // next state
    // ************************************************************
    // one combinational pass computes every register update
    always_comb begin
        brf_bank_e  tb;
        logic [2:0] slot;
        logic [1:0] a;
        logic [4:0] rp;
        logic [31:0] pcv;
        tb      = mode_bank(exc_req.mode);
        slot    = stat_slot(bank);
        a       = mem_req.addr[1:0];
        rp      = 5'h0;
        pcv     = 32'h0;
        next_st = st;
        next_st.rst_sync = {st.rst_sync[0], 1'b1};
        // endian strap caught only while reset is still held
        if (!rst_int_b) begin
            next_st.big_end = big_endian_cfg;
        end
        // general write; compact indices alias wide ones
        if (wr_req.en) begin
            next_st.gpr[phys(bank, wr_req.idx)] = wr_req.data;
        end
        // branch with link copies r15 into current link
        if (branch_with_link) begin
            next_st.gpr[phys(bank, `BRF_IDX_LINK)] = st.gpr[`BRF_IDX_PC];
        end
        // mode write only when privileged; system reached only here
        if (status_wr && priv) begin
            next_st.stat[0] = status_wdata;
        end else if (status_wr) begin
            next_st.stat[0][31:8] = status_wdata[31:8]; // user keeps control bits
        end
        // saved status write only where one exists
        if (saved_status_wr && slot != 3'h0) begin
            next_st.stat[slot] = saved_status_wdata;
        end
        // exception entry: save status, load link, switch mode
        if (exc_req.en && tb != BRF_BANK_USER) begin
            next_st.stat[stat_slot(tb)] = st.stat[0];
            next_st.gpr[phys(tb, `BRF_IDX_LINK)] = exc_req.ret;
            next_st.stat[0][`BRF_STAT_MODE_HI:`BRF_STAT_MODE_LO] = exc_req.mode;
            next_st.stat[0][`BRF_STAT_T_BIT] = 1'b0;                 // handlers run wide
        end
        // visible read; r15 gets its state masking
        rp = phys(bank, rd_idx);
        pcv = compact ? {st.gpr[`BRF_IDX_PC][31:1], 1'b0}
                    : {st.gpr[`BRF_IDX_PC][31:2], 2'h0};
        if (rd_idx == `BRF_IDX_PC) begin
            next_st.rd_data = pcv;
        end else begin
            next_st.rd_data = st.gpr[rp];
        end
        // byte lane steering; big endian swaps the lanes for bytes and halves, words pass unchanged
        next_st.misaligned = 1'b0;
        next_st.lane_be    = 4'h0;
        next_st.lane_wdata = 32'h0;
        next_st.lane_rdata = 32'h0;
        case (mem_req.size)
            BRF_SIZE_BYTE: begin
                next_st.lane_wdata = {4{mem_req.wdata[7:0]}};
                next_st.lane_be    = st.big_end ? (4'h8 >> a) : (4'h1 << a);
                next_st.lane_rdata = {24'h0, mem_rdata[8*(st.big_end ? 2'(3 - a) : a) +: 8]};
            end
            BRF_SIZE_HALF: begin
                next_st.misaligned = a[0];
                next_st.lane_wdata = {2{mem_req.wdata[15:0]}};
                next_st.lane_be    = (a[1] ^ st.big_end) ? 4'hC : 4'h3;
                next_st.lane_rdata = {16'h0, mem_rdata[16*(a[1] ^ st.big_end) +: 16]};
            end
            BRF_SIZE_WORD: begin
                next_st.misaligned = (a != 2'h0);
                next_st.lane_wdata = mem_req.wdata;
                next_st.lane_be    = 4'hF;
                next_st.lane_rdata = mem_rdata;
            end
            default: begin
                next_st.misaligned = 1'b1;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    // all state clears asynchronously, current status to D3; all but sync bits and strap held until the released copy
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st          <= '0;
            st.stat[0]  <= `BRF_STAT_RESET;
        end else if (!rst_int_b) begin
            st          <= '0;
            st.stat[0]  <= `BRF_STAT_RESET;
            st.rst_sync <= next_st.rst_sync;
            st.big_end  <= next_st.big_end;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data              = st.rd_data;
    assign program_counter      = compact ? {st.gpr[`BRF_IDX_PC][31:1], 1'b0}
                                        : {st.gpr[`BRF_IDX_PC][31:2], 2'h0};
    assign stack_pointer        = st.gpr[phys(bank, `BRF_IDX_SP)];
    assign return_link_register = st.gpr[phys(bank, `BRF_IDX_LINK)];
    assign current_status_word  = st.stat[0];
    assign saved_status_word    = (stat_slot(bank) != 3'h0) ? st.stat[stat_slot(bank)] : 32'h0;
    assign privileged           = priv;
    assign compact_state        = compact;
    assign lane_wdata           = st.lane_wdata;
    assign lane_be              = st.lane_be;
    assign lane_rdata           = st.lane_rdata;
    assign misaligned           = st.misaligned;
endmodule

// file: rtl/brf_map.svh
// constants for the banked core register file: mode codes, field positions, counts
`ifndef BRF_MAP_SVH
`define BRF_MAP_SVH
`define BRF_MODE_USER    5'h10
`define BRF_MODE_FAST    5'h11
`define BRF_MODE_IRQ     5'h12
`define BRF_MODE_SVC     5'h13
`define BRF_MODE_ABT     5'h17
`define BRF_MODE_UND     5'h1B
`define BRF_MODE_SYS     5'h1F
`define BRF_STAT_T_BIT   5
`define BRF_STAT_MODE_HI 4
`define BRF_STAT_MODE_LO 0
`define BRF_STAT_RESET   32'h000000D3
`define BRF_PHYS_GPR     31
`define BRF_PHYS_STAT    6
`define BRF_IDX_SP       4'hD
`define BRF_IDX_LINK     4'hE
`define BRF_IDX_PC       4'hF
`define BRF_IDX_FAST_LO  4'h8
`endif

// file: rtl/brf_pkg.sv
// types for the banked core register file
package brf_pkg;
    // bank selected by the current mode
    typedef enum logic [5:0] {
        BRF_BANK_USER = 6'h01,
        BRF_BANK_FAST = 6'h02,
        BRF_BANK_IRQ  = 6'h04,
        BRF_BANK_SVC  = 6'h08,
        BRF_BANK_ABT  = 6'h10,
        BRF_BANK_UND  = 6'h20
    } brf_bank_e;
    // access size on the memory side
    typedef enum logic [1:0] {
        BRF_SIZE_BYTE = 2'h0,
        BRF_SIZE_HALF = 2'h1,
        BRF_SIZE_WORD = 2'h2
    } brf_size_e;
    // general register write request
    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic [31:0] data;
    } brf_wr_s;
    // exception entry request
    typedef struct packed {
        logic        en;
        logic [4:0]  mode;
        logic [31:0] ret;
    } brf_exc_s;
    // memory lane request
    typedef struct packed {
        logic [31:0] addr;
        brf_size_e   size;
        logic [31:0] wdata;
    } brf_mem_s;
    // all state of the register file
    typedef struct packed {
        logic [1:0]           rst_sync;
        logic                 big_end;
        logic [30:0][31:0]    gpr;
        logic [5:0][31:0]     stat;
        logic [31:0]          rd_data;
        logic [31:0]          lane_wdata;
        logic [3:0]           lane_be;
        logic                 misaligned;
        logic [31:0]          lane_rdata;
    } brf_state_s;
endpackage

// file: tb/brf_mem_model.sv
// memory partner model: fixed word pattern per aligned address
`timescale 1ns/100ps
module brf_mem_model (
    input  wire logic [31:0] addr,
    output logic [31:0]      rdata
);
    // ******
    // read path
    // ******
    // low bits ignored so every word starts on a multiple of four
    assign rdata = {addr[31:2], 2'h0} ^ 32'hC3A5_0F96;
endmodule

// file: tb/brf_core_monitor.sv
// concurrent checks on the register file ports
`timescale 1ns/100ps
module brf_monitor
    import brf_pkg::*;
(
    input wire logic              clock,
    input wire logic              rst_b,
    input wire logic              big_endian_cfg,
    input wire logic              branch_with_link,
    input wire logic              status_wr,
    input wire logic              saved_status_wr,
    input wire brf_pkg::brf_wr_s  wr_req,
    input wire brf_pkg::brf_exc_s exc_req,
    input wire brf_pkg::brf_mem_s mem_req,
    input wire logic [31:0]       program_counter,
    input wire logic [31:0]       return_link_register,
    input wire logic [31:0]       current_status_word,
    input wire logic [31:0]       saved_status_word,
    input wire logic              privileged,
    input wire logic              compact_state,
    input wire logic [3:0]        lane_be,
    input wire logic              misaligned
);
    import brf_pkg::*;
    // ******
    // helpers
    // ******
    logic [2:0] up; // edges since release; design sync needs two, lanes one more
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) up <= 3'h0;
        else if (up != 3'h4) up <= up + 3'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b || up != 3'h4);
    // legal exception entry request
    sequence s_exc_in;
        exc_req.en && exc_req.mode inside {5'h11, 5'h12, 5'h13, 5'h17, 5'h1B};
    endsequence
    // ******
    // assertions
    // ******
    a_exc_link: assert property (s_exc_in |=> return_link_register == $past(exc_req.ret))
        else $error("link not loaded on entry");
    a_exc_mode: assert property (s_exc_in |=> current_status_word[4:0] == $past(exc_req.mode) && !compact_state)
        else $error("mode or state wrong on entry");
    a_exc_saved: assert property (s_exc_in |=> saved_status_word == $past(current_status_word))
        else $error("saved status wrong");
    a_bwl_link: assert property (branch_with_link && !wr_req.en && !status_wr && !saved_status_wr && !exc_req.en
        |=> return_link_register[31:2] == $past(program_counter[31:2])) else $error("link not copied");
    a_sys_no_exc: assert property (exc_req.en && exc_req.mode == 5'h1F |=> $stable(current_status_word))
        else $error("exception entered system");
    a_user_lock: assert property (status_wr && !exc_req.en && current_status_word[4:0] == 5'h10
        |=> current_status_word[7:0] == $past(current_status_word[7:0])) else $error("user changed control bits");
    a_priv_mode: assert property (privileged == (current_status_word[4:0] != 5'h10))
        else $error("privilege wrong");
    a_state_view: assert property (compact_state == current_status_word[5])
        else $error("state view wrong");
    a_pc_wide: assert property (!compact_state |-> program_counter[1:0] == 2'h0)
        else $error("wide counter unmasked");
    a_pc_compact: assert property (compact_state |-> !program_counter[0])
        else $error("compact counter unmasked");
    a_no_saved: assert property (current_status_word[4:0] inside {5'h10, 5'h1F} |-> saved_status_word == 32'h0)
        else $error("saved status in user view");
    a_be_little: assert property (!big_endian_cfg && $past(mem_req.size) == BRF_SIZE_BYTE
        |-> lane_be == 4'h1 << $past(mem_req.addr[1:0])) else $error("little lane wrong");
    a_be_big: assert property (big_endian_cfg && $past(mem_req.size) == BRF_SIZE_BYTE
        |-> lane_be == 4'h8 >> $past(mem_req.addr[1:0])) else $error("big lane wrong");
    a_misalign: assert property ($past(mem_req.size) == BRF_SIZE_WORD && $past(mem_req.addr[1:0]) != 2'h0
        |-> misaligned) else $error("misaligned word missed");
endmodule

// file: tb/tb_top.sv
// self-checking bench for the banked register file
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import brf_pkg::*;
    // ******
    // signals
    // ******
    logic        clock = 0, rst_b = 0, big = 0, bwl = 0, swr = 0;
    logic [3:0]  rd_idx = 4'h0, be;
    logic [31:0] swd = 32'h0, rdd, pc, sp, lr, cs, ss, lrd, mrd, lwd;
    logic        sswr = 0;
    logic [31:0] sswd = 32'h0;
    logic        priv, cmp, mis;
    brf_wr_s     wr_req = '0;
    brf_exc_s    exc_req = '0;
    brf_mem_s    mem_req = '0;
    logic [3:0]  qs[$];  // which output
    logic [31:0] qv[$];  // expected value
    int          failures = 0, compares = 0, cycles = 0, seed = 32'h879B, r;
    logic [4:0]  md[4] = '{5'h12, 5'h13, 5'h17, 5'h1B};
    initial forever #12.5 clock = ~clock;
    brf_core DUT (.clock, .rst_b, .big_endian_cfg(big), .rd_idx, .wr_req, .branch_with_link(bwl),
        .exc_req, .status_wr(swr), .status_wdata(swd), .saved_status_wr(sswr), .saved_status_wdata(sswd),
        .mem_req, .mem_rdata(mrd), .rd_data(rdd), .program_counter(pc), .stack_pointer(sp),
        .return_link_register(lr), .current_status_word(cs), .saved_status_word(ss), .privileged(priv),
        .compact_state(cmp), .lane_wdata(lwd), .lane_be(be), .lane_rdata(lrd), .misaligned(mis));
    brf_mem_model u_mem (.addr(mem_req.addr), .rdata(mrd));
    // ******
    // helpers
    // ******
    function automatic logic [31:0] pick(logic [3:0] s);
        case (s)
            0: return rdd; 1: return pc; 2: return sp; 3: return lr; 4: return cs;
            5: return ss; 6: return {28'h0, be}; 7: return {31'h0, mis}; 8: return lrd;
            10: return lwd;
            default: return {31'h0, priv};
        endcase
    endfunction
    task automatic ex(input logic [3:0] s, input logic [31:0] v);
        qs.push_back(s);
        qv.push_back(v);
    endtask
    // one edge, then drop every pulse
    task automatic cyc;
        @(posedge clock);
        @(negedge clock);
        wr_req.en = 0; exc_req.en = 0; bwl = 0; swr = 0; sswr = 0;
    endtask
    task automatic final_report;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // every queued note, oldest first, against settled outputs
    always @(posedge clock) begin
        #1;
        while (qs.size() > 0) begin
            `CHK(pick(qs[0]), qv[0])
            void'(qs.pop_front());
            void'(qv.pop_front());
        end
    end
    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin failures++; final_report(); end
    end
    // ******
    // scenarios, once per byte order
    // ******
    initial begin
        for (int e = 0; e < 2; e++) begin
            @(negedge clock); rst_b = 0; big = e[0]; // strap only moves in reset
            repeat (5) @(negedge clock);
            rst_b = 1;
            repeat (3) @(negedge clock);
            ex(4, 32'hD3); ex(9, 1); cyc;
            wr_req = '{1'b1, 4'hD, 32'h1111_0000}; ex(2, 32'h1111_0000); cyc;
            wr_req = '{1'b1, 4'h8, 32'h8888}; rd_idx = 4'h8; cyc;
            exc_req = '{1'b1, 5'h11, 32'h4444}; ex(3, 32'h4444); ex(5, 32'hD3); ex(4, 32'hD1); cyc;
            ex(2, 0); ex(0, 0); cyc;
            swr = 1; swd = 32'h1F; ex(2, 0); ex(5, 0); cyc;
            ex(0, 32'h8888); cyc;
            swr = 1; swd = 32'h13; ex(2, 32'h1111_0000); cyc;
            sswr = 1; sswd = 32'h0000_5A5A; ex(5, 32'h0000_5A5A); cyc;
            foreach (md[i]) begin
                exc_req = '{1'b1, md[i], 32'(i)}; ex(3, 32'(i)); ex(4, {27'h0, md[i]}); cyc;
            end
            wr_req = '{1'b1, 4'hF, 32'h1237}; ex(1, 32'h1234); cyc;
            bwl = 1; ex(3, 32'h1237); cyc;
            swr = 1; swd = 32'h33; ex(1, 32'h1236); ex(4, 32'h33); cyc;
            wr_req = '{1'b1, 4'hD, 32'h5555}; ex(2, 32'h5555); cyc;
            swr = 1; swd = 32'hAB00_0010; ex(9, 0); cyc;
            swr = 1; swd = 32'h5600_0013; ex(4, 32'h5600_0010); cyc;
            exc_req = '{1'b1, 5'h1F, 32'h0}; ex(4, 32'h5600_0010); cyc;
            repeat (24) begin
                r = $random(seed);
                mem_req = '{r, brf_size_e'(r[5:4] == 2'h3 ? 2'h2 : r[5:4]), ~r};
                cyc;
                ex(7, {31'h0, mem_req.size == BRF_SIZE_WORD ? |r[1:0] : mem_req.size == BRF_SIZE_HALF && r[0]});
                if (mem_req.size == BRF_SIZE_HALF && !r[0]) ex(6, (r[1] ^ big) ? 32'hC : 32'h3);
                if (mem_req.size == BRF_SIZE_WORD) ex(10, ~r);
                if (mem_req.size == BRF_SIZE_WORD && r[1:0] == 2'h0) ex(8, mrd);
                cyc;
            end
        end
        final_report();
    end
endmodule
bind brf_core brf_monitor u_mon (.clock, .rst_b, .big_endian_cfg, .branch_with_link, .status_wr,
    .saved_status_wr, .wr_req, .exc_req, .mem_req, .program_counter, .return_link_register,
    .current_status_word, .saved_status_word, .privileged, .compact_state, .lane_be, .misaligned);
